/* logic/kms_pkg.sv */
package kms_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SCAN_HZ = 30_000;
  localparam int unsigned SCAN_DIV = CLK_HZ / SCAN_HZ;
  localparam int unsigned RPT_HZ = 10;
  localparam int unsigned RPT_DIV = CLK_HZ / RPT_HZ;
  localparam int unsigned HOLD_MS = 1000;
  localparam int unsigned HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned RKEY_MS = 12;
  localparam int unsigned RKEY_CYC = CLK_HZ / 1000 * RKEY_MS;
  localparam int unsigned RST_MS = 1000;
  localparam int unsigned RST_CYC = CLK_HZ / 1000 * RST_MS;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned ROWS = 16;
  localparam int unsigned COLS = 8;
  localparam int unsigned CODE_W = 10;
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
  localparam int unsigned SHIFT_BIT = 7;
  localparam int unsigned CTRL_BIT = 8;
  localparam int unsigned CAPS_BIT = 9;
  typedef enum logic [1:0] {
    KMS_IDLE = 2'b00,
    KMS_HELD = 2'b01,
    KMS_WAIT_REL = 2'b10
  } kms_scan_t;
endpackage

/* logic/kms_buf2.sv */
`timescale 1ns/100ps
module kms_buf2 #(
  parameter int unsigned W = 10
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic [W-1:0] nxt_mem [2];
  logic wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [W-1:0] rd_ff, nxt_rd;
  logic push, pop;

  always_comb begin
    push = in_valid && (cnt_ff != 2'd2);
    pop = out_ready && (cnt_ff != 2'd0);
    nxt_mem = mem_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wp_ff] = in_data;
      nxt_wp = ~wp_ff;
    end
    if (pop) begin
      nxt_rp = ~rp_ff;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'd1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'd1;
    end
    // registered head; bypass when writing into an empty slot being read
    nxt_rd = nxt_mem[nxt_rp];
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wp_ff <= 1'b0;
      rp_ff <= 1'b0;
      cnt_ff <= 2'd0;
      rd_ff <= '0;
    end else begin
      mem_ff <= nxt_mem;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
      rd_ff <= nxt_rd;
    end
  end

  assign in_ready = (cnt_ff != 2'd2);
  assign out_valid = (cnt_ff != 2'd0);
  assign out_data = rd_ff;
endmodule // kms_buf2

/* logic/kms_scanner.sv */
`timescale 1ns/100ps
module kms_scanner
  import kms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [COLS-1:0] matrix_return_lines,
  input wire logic shift_key,
  input wire logic ctrl_key,
  input wire logic capitals_lock_key,
  input wire logic repeat_key,
  input wire logic reset_key,
  input wire logic host_ack,
  output logic [ROWS-1:0] row_drive_ff,
  output logic [3:0] scan_select_ff,
  output logic key_held_ff,
  output logic key_accepted_ff,
  output logic strobe_ff,
  output logic [CODE_W-1:0] code_ff,
  output logic proc_reset_ff
);
  ////////////////////////////////////////////////////////////////////////
  // timing sources
  logic [CNT_W-1:0] scan_cnt_ff, nxt_scan_cnt;
  logic [CNT_W-1:0] rpt_cnt_ff, nxt_rpt_cnt;
  logic scan_tick, rpt_tick;

  always_comb begin
    scan_tick = (scan_cnt_ff == CNT_W'(SCAN_DIV - 1));
    rpt_tick = (rpt_cnt_ff == CNT_W'(RPT_DIV - 1));
    nxt_scan_cnt = scan_tick ? '0 : scan_cnt_ff + 1'b1;
    nxt_rpt_cnt = rpt_tick ? '0 : rpt_cnt_ff + 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      scan_cnt_ff <= '0;
      rpt_cnt_ff <= '0;
    end else begin
      scan_cnt_ff <= nxt_scan_cnt;
      rpt_cnt_ff <= nxt_rpt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // matrix scan and key-held tracking
  kms_scan_t st_ff, nxt_st;
  logic [3:0] nxt_sel;
  logic [ROWS-1:0] nxt_rows;
  logic [2:0] col_idx;
  logic col_hit;
  logic [6:0] key_ff, nxt_key;
  logic nxt_held;
  logic press;
  logic rescan;
  logic [CNT_W-1:0] rk_cnt_ff, nxt_rk_cnt;

  always_comb begin
    col_hit = 1'b0;
    col_idx = 3'd0;
    for (int i = COLS - 1; i >= 0; i--) begin
      if (!matrix_return_lines[i]) begin
        col_hit = 1'b1;
        col_idx = 3'(i);
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_sel = scan_select_ff;
    nxt_key = key_ff;
    nxt_held = key_held_ff;
    press = 1'b0;
    // repeat key: 12 ms pulse train, each pulse forces a rescan read while a key is held (KMS_HELD)
    rescan = 1'b0;
    nxt_rk_cnt = '0;
    if (repeat_key) begin
      if (rk_cnt_ff == CNT_W'(RKEY_CYC - 1)) begin
        nxt_rk_cnt = '0;
        rescan = 1'b1;
      end else begin
        nxt_rk_cnt = rk_cnt_ff + 1'b1;
      end
    end
    if (scan_tick) begin
      case (st_ff)
        KMS_IDLE: begin
          if (col_hit) begin
            nxt_key = {scan_select_ff, col_idx};
            nxt_held = 1'b1;
            press = 1'b1;
            nxt_st = KMS_HELD;
          end else begin
            nxt_sel = scan_select_ff + 4'd1;
          end
        end
        KMS_HELD: begin
          // row stays driven so release is seen on the same line
          if (!matrix_return_lines[key_ff[2:0]]) begin
            nxt_held = 1'b1;
          end else begin
            nxt_held = 1'b0;
            nxt_st = KMS_IDLE;
          end
        end
        default: begin
          nxt_st = KMS_IDLE;
        end
      endcase
    end
    if (rescan && st_ff == KMS_HELD) begin
      press = 1'b1;
    end
    nxt_rows = {ROWS{1'b1}};
    nxt_rows[nxt_sel] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff <= KMS_IDLE;
      scan_select_ff <= 4'h0;
      row_drive_ff <= 16'hFFFE;
      key_ff <= 7'h00;
      key_held_ff <= 1'b0;
      rk_cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      scan_select_ff <= nxt_sel;
      row_drive_ff <= nxt_rows;
      key_ff <= nxt_key;
      key_held_ff <= nxt_held;
      rk_cnt_ff <= nxt_rk_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // holdoff and repeat gating
  logic [CNT_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  logic rpt_fire;
  logic [CODE_W-1:0] word;

  always_comb begin
    nxt_hold_cnt = hold_cnt_ff;
    if (press && !rescan) begin
      nxt_hold_cnt = CNT_W'(HOLD_CYC);
    end else if (hold_cnt_ff != '0) begin
      nxt_hold_cnt = hold_cnt_ff - 1'b1;
    end
    rpt_fire = rpt_tick && (hold_cnt_ff == '0) && key_held_ff
               && (st_ff == KMS_HELD);
    word = '0;
    word[6:0] = key_ff;
    word[SHIFT_BIT] = shift_key;
    word[CTRL_BIT] = ctrl_key;
    word[CAPS_BIT] = capitals_lock_key;
    if (press) begin
      word[6:0] = nxt_key;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hold_cnt_ff <= '0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // code buffer: a stall by the host loses an event only when the buffer and the pending slot are both full
  logic buf_in_ready, buf_out_valid, buf_pop, buf_push;
  logic [CODE_W-1:0] buf_out_data, buf_word;

  // two events queue here, a third waits in the pending slot
  kms_buf2 #(.W(CODE_W)) u_buf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(buf_push),
    .in_ready(buf_in_ready),
    .in_data(buf_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // pending slot in front of the buffer
  logic evt;
  logic pend_ff, nxt_pend;
  logic [CODE_W-1:0] pend_word_ff, nxt_pend_word;

  always_comb begin
    evt = press || rpt_fire;
    nxt_pend = pend_ff;
    nxt_pend_word = pend_word_ff;
    buf_push = 1'b0;
    buf_word = word;
    if (pend_ff) begin
      // oldest first; an event arriving while full and pending is lost
      buf_word = pend_word_ff;
      if (buf_in_ready) begin
        buf_push = 1'b1;
        nxt_pend = evt;
        nxt_pend_word = word;
      end
    end else if (evt) begin
      if (buf_in_ready) begin
        buf_push = 1'b1;
      end else begin
        nxt_pend = 1'b1;
        nxt_pend_word = word;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      pend_word_ff <= CODE_RST;
    end else begin
      pend_ff <= nxt_pend;
      pend_word_ff <= nxt_pend_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe latch toward the host port
  logic nxt_strobe, nxt_acc;
  logic [CODE_W-1:0] nxt_code;

  always_comb begin
    nxt_strobe = strobe_ff;
    nxt_acc = key_accepted_ff;
    nxt_code = code_ff;
    buf_pop = 1'b0;
    if (strobe_ff && host_ack) begin
      nxt_strobe = 1'b0;
      nxt_acc = 1'b1;
    end else if (!strobe_ff && buf_out_valid && !host_ack) begin
      // waiting for ack to fall keeps each strobe a distinct event
      nxt_strobe = 1'b1;
      nxt_code = buf_out_data;
      nxt_acc = 1'b0;
      buf_pop = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      strobe_ff <= 1'b0;
      key_accepted_ff <= 1'b0;
      code_ff <= CODE_RST;
    end else begin
      strobe_ff <= nxt_strobe;
      key_accepted_ff <= nxt_acc;
      code_ff <= nxt_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset key: must outlast a one second timer
  typedef enum logic [1:0] {
    KMS_RST_OFF = 2'b00,
    KMS_RST_TIMING = 2'b01,
    KMS_RST_FIRED = 2'b10
  } kms_rst_t;
  kms_rst_t rst_st_ff, nxt_rst_st;
  logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
  logic nxt_preset;

  always_comb begin
    nxt_rst_st = rst_st_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_preset = proc_reset_ff;
    case (rst_st_ff)
      KMS_RST_OFF: begin
        nxt_rst_cnt = '0;
        nxt_preset = 1'b0;
        if (reset_key) begin
          nxt_rst_cnt = CNT_W'(1);
          nxt_rst_st = KMS_RST_TIMING;
        end
      end
      KMS_RST_TIMING: begin
        if (!reset_key) begin
          // early release abandons the timer, no reset is issued
          nxt_rst_st = KMS_RST_OFF;
        end else if (rst_cnt_ff == CNT_W'(RST_CYC - 1)) begin
          nxt_preset = 1'b1;
          nxt_rst_st = KMS_RST_FIRED;
        end else begin
          nxt_rst_cnt = rst_cnt_ff + 1'b1;
        end
      end
      KMS_RST_FIRED: begin
        if (!reset_key) begin
          nxt_preset = 1'b0;
          nxt_rst_st = KMS_RST_OFF;
        end
      end
      default: begin
        nxt_preset = 1'b0;
        nxt_rst_st = KMS_RST_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rst_st_ff <= KMS_RST_OFF;
      rst_cnt_ff <= '0;
      proc_reset_ff <= 1'b0;
    end else begin
      rst_st_ff <= nxt_rst_st;
      rst_cnt_ff <= nxt_rst_cnt;
      proc_reset_ff <= nxt_preset;
    end
  end
endmodule // kms_scanner

/* bench/kms_chk.sv */
`timescale 1ns/100ps
module kms_chk
  import kms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [COLS-1:0] matrix_return_lines,
  input wire logic shift_key,
  input wire logic ctrl_key,
  input wire logic capitals_lock_key,
  input wire logic repeat_key,
  input wire logic reset_key,
  input wire logic host_ack,
  input wire logic [ROWS-1:0] row_drive_ff,
  input wire logic [3:0] scan_select_ff,
  input wire logic key_held_ff,
  input wire logic key_accepted_ff,
  input wire logic strobe_ff,
  input wire logic [CODE_W-1:0] code_ff,
  input wire logic proc_reset_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_press;
    $rose(key_held_ff) && !strobe_ff && !host_ack;
  endsequence
  sequence s_ack;
    strobe_ff && host_ack;
  endsequence
  a_row_decode: assert property (
    row_drive_ff == ~(16'h0001 << scan_select_ff)) else $error("row decode");
  a_scan_pace: assert property (
    $changed(scan_select_ff) |=> $stable(scan_select_ff)[*8])
    else $error("scan too fast");
  a_press_strobe: assert property (
    s_press |-> ##[1:4] $rose(strobe_ff)) else $error("no strobe");
  a_strobe_stands: assert property (
    strobe_ff && !host_ack |=> strobe_ff && $stable(code_ff))
    else $error("strobe not held");
  a_ack_clears: assert property (
    s_ack |=> !strobe_ff) else $error("ack no clear");
  a_ack_marks: assert property (
    s_ack |=> key_accepted_ff) else $error("ack no mark");
  a_new_strobe: assert property (
    $rose(strobe_ff) |-> !host_ack && !key_accepted_ff)
    else $error("strobe during ack");
  a_reset_needs: assert property (
    $rose(proc_reset_ff) |-> $past(reset_key) && $past(reset_key, 2))
    else $error("reset without key");
  a_reset_drop: assert property (
    !reset_key |=> !proc_reset_ff) else $error("reset stuck");
endmodule // kms_chk
bind kms_scanner kms_chk u_chk (.*);

/* bench/kms_host_model.sv */
`timescale 1ns/100ps
module kms_host_model
  import kms_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] ack_dly,
  input wire logic strobe_ff,
  input wire logic [CODE_W-1:0] code_ff,
  output logic host_ack,
  output logic [CODE_W-1:0] cap_code
);
  logic [7:0] wait_cnt;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      host_ack <= 1'b0;
      wait_cnt <= 8'h00;
      cap_code <= '0;
    end else if (strobe_ff && !host_ack) begin
      wait_cnt <= wait_cnt + 8'h01;
      if (wait_cnt == ack_dly) begin
        cap_code <= code_ff;
        host_ack <= 1'b1;
      end
    end else if (!strobe_ff) begin
      // released only after strobe idles, so no event is double counted
      host_ack <= 1'b0;
      wait_cnt <= 8'h00;
    end
  end
endmodule // kms_host_model

/* bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import kms_pkg::*;
  logic clk_sys = 0;
  logic nrst = 0;
  logic [COLS-1:0] matrix_return_lines = 8'hff;
  logic shift_key = 0, ctrl_key = 0, capitals_lock_key = 0;
  logic reset_key = 0, repeat_key = 0, pressed = 0;
  logic [7:0] ack_dly = 8'h00;
  logic [3:0] key_row = 0;
  logic [2:0] key_col = 0;
  logic host_ack, key_held_ff, key_accepted_ff, strobe_ff, proc_reset_ff;
  logic [ROWS-1:0] row_drive_ff;
  logic [3:0] scan_select_ff;
  logic [CODE_W-1:0] code_ff, cap_code;
  int errors = 0, compares = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  kms_scanner u_dut (.clk_sys, .nrst, .matrix_return_lines, .shift_key,
    .ctrl_key, .capitals_lock_key, .repeat_key, .reset_key,
    .host_ack, .row_drive_ff, .scan_select_ff, .key_held_ff,
    .key_accepted_ff, .strobe_ff, .code_ff, .proc_reset_ff);
  kms_host_model u_host (.clk_sys, .nrst, .ack_dly, .strobe_ff, .code_ff,
    .host_ack, .cap_code);
  // one pressed key; pull-ups return the lines high otherwise
  always @(posedge clk_sys) begin
    matrix_return_lines <= (pressed && !row_drive_ff[key_row]) ?
      ~(8'h01 << key_col) : 8'hff;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s exp %h got %h", name, exp, got);
    end
  endtask
  // a full scan pass is about 27k cycles, so bound each wait above that
  task automatic wait_lvl(bit held, logic lvl);
    int n;
    n = 0;
    while ((held ? key_held_ff : strobe_ff) !== lvl && n < 30000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(held ? "held_wait" : "strobe_wait", lvl, held ? key_held_ff :
      strobe_ff);
  endtask
  task automatic press(logic [3:0] r, logic [2:0] c, logic [2:0] m,
    logic [7:0] dly);
    logic [CODE_W-1:0] exp;
    exp = {m, r, c};
    @(posedge clk_sys);
    key_row <= r;
    key_col <= c;
    ack_dly <= dly;
    pressed <= 1'b1;
    {capitals_lock_key, ctrl_key, shift_key} <= m;
    wait_lvl(0, 1);
    chk("held", 1, key_held_ff);
    chk("code", exp, code_ff);
    chk("acc_low", 0, key_accepted_ff);
    wait_lvl(0, 0);
    chk("acc_high", 1, key_accepted_ff);
    chk("captured", exp, cap_code);
    chk("still_held", 1, key_held_ff);
  endtask
  task automatic release_key();
    @(posedge clk_sys);
    pressed <= 1'b0;
    reset_key <= 1'b1;
    repeat_key <= 1'b1;
    repeat (100) @(posedge clk_sys);
    reset_key <= 1'b0;
    repeat_key <= 1'b0;
    @(negedge clk_sys);
    chk("proc_reset", 0, proc_reset_ff);
    chk("no_rescan", 0, strobe_ff);
    wait_lvl(1, 0);
    chk("no_restrobe", 0, strobe_ff);
  endtask
  task automatic rst_chk();
    @(negedge clk_sys);
    chk("row_rst", 16'hfffe, row_drive_ff);
    chk("sel_rst", 0, scan_select_ff);
    chk("held_rst", 0, key_held_ff);
    chk("acc_rst", 0, key_accepted_ff);
    chk("strobe_rst", 0, strobe_ff);
    chk("code_rst", CODE_RST, code_ff);
    chk("preset_rst", 0, proc_reset_ff);
  endtask
  task automatic mid_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rst_chk();
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rst_chk();
    press(4'h5, 3'h6, 3'h7, 8'h00);
    mid_reset();
    release_key();
    press(4'hf, 3'h0, 3'h0, 8'hc8);
    release_key();
    wrap_up();
  end
endmodule // testbench
